// *** src/bus_pin_control_bits.sv ***
// Purpose: Byte-order strap capture and pin drive/float control
// Assumes: Standby and bus release come from logic on clk
// Notes: Bus clock pin is modelled as a toggle at half the clk rate
//        The strap is sampled once per reset, which stands in for power-on
//        Keeping clock pins driven for some clock modes is left to software
//        Unmapped addresses answer with zero and ignore writes
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps

// How it works
// - Bit 4 reads one, writes ignored
// - Strap latched after reset, read-only flag
// - Flag zero big-endian, one little-endian
// - One byte-order output for all spaces
// - Secondary clock low unless drive bit set
// - Memory pins float in standby unless set
// - Memory pins float whenever bus released
// - Clock pins float in standby or release unless clock float set
module bus_pin_control_bits #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic byte_order_strap_pin,
	input wire logic standby,
	input wire logic bus_released,
	output logic little_endian,
	output logic bus_clock_pin,
	output logic secondary_clock_pin,
	output logic memory_pins_oe_n,
	output logic clock_pins_oe_n
);

	// Elaboration checks; the decoder compares the whole low byte
	if (ADDR_W < 8) begin : g_addr_narrow
		$error("ADDR_W must be at least 8");
	end
	if (ADDR_W > 32) begin : g_addr_wide
		$error("ADDR_W must be at most 32");
	end

	////////////////////////////////////////////////////////////////////////
	// Shared decoding

	// True when the byte address selects the control word
	function automatic logic ctrl_hit(input logic [ADDR_W-1:0] adr);
		logic [ADDR_W-1:0] ctrl;
		ctrl = ADDR_W'(bus_pin_ctrl_pkg::CTRL_OFFSET); // Upper address bits must be zero
		return adr == ctrl;
	endfunction : ctrl_hit

	// Active-low enable: float while cond holds, unless software keeps it driven
	function automatic logic float_n(input logic cond, input logic keep);
		return cond && !keep;
	endfunction : float_n

	////////////////////////////////////////////////////////////////////////
	// Strap capture: two-stage synchroniser, then one sample per reset
	typedef enum logic [1:0] {
		STRAP_SETTLING = 2'b01,
		STRAP_HELD = 2'b10
	} strap_state_e;

	logic strap_meta_q;
	logic strap_sync_q;
	logic [1:0] settle_q;
	logic [1:0] settle_d;
	strap_state_e strap_state_q;
	strap_state_e strap_state_d;
	logic order_q;
	logic order_d;

	// Strap capture waits for the synchroniser to fill after reset
	always_comb begin
		settle_d = settle_q;
		strap_state_d = strap_state_q;
		order_d = order_q;
		case (strap_state_q)
			STRAP_SETTLING: begin
				if (settle_q == bus_pin_ctrl_pkg::STRAP_SETTLE_CYCLES) begin
					strap_state_d = STRAP_HELD;
					order_d = strap_sync_q;
				end else begin
					settle_d = settle_q + 2'h1;
				end
			end
			STRAP_HELD: begin
				order_d = order_q; // Held until the next reset, writes cannot reach it
			end
			default: begin
				strap_state_d = STRAP_SETTLING;
			end
		endcase
	end

	// Strap state; the synchroniser is the only reader of the raw pin
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_meta_q <= 1'b0;
			strap_sync_q <= 1'b0;
			settle_q <= 2'h0;
			strap_state_q <= STRAP_SETTLING;
			order_q <= 1'b0;
		end else begin
			strap_meta_q <= byte_order_strap_pin;
			strap_sync_q <= strap_meta_q;
			settle_q <= settle_d;
			strap_state_q <= strap_state_d;
			order_q <= order_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register bus: writable bits and the registered answer
	logic [2:0] rw_q;
	logic [2:0] rw_d;
	logic ack_q;
	logic ack_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic req;
	logic hit;
	logic wr_en;
	logic [31:0] word;

	// Register view; reserved bit 4 reads one, bits above it read zero
	always_comb begin
		word = 32'h0000_0000;
		word[bus_pin_ctrl_pkg::RESERVED_BIT] = bus_pin_ctrl_pkg::RESERVED_VALUE;
		word[bus_pin_ctrl_pkg::BYTE_ORDER_BIT] = order_q;
		word[2:0] = rw_q;
	end

	// Single-cycle answer; unmapped addresses ack with zero data
	always_comb begin
		req = wb_cyc_i && wb_stb_i;
		hit = ctrl_hit(wb_adr_i);
		ack_d = req && !ack_q; // Falls after one cycle even if stb stays high
		wr_en = ack_d && hit && wb_we_i && wb_sel_i[0]; // Lane 0 holds every writable bit
		rw_d = rw_q;
		rdata_d = 32'h0000_0000;
		// Read data stands only in the answer cycle, zero otherwise
		if (ack_d && hit) begin
			rdata_d = word;
		end
		if (wr_en) begin
			rw_d = wb_dat_i[2:0]; // Bits 4 and 3 not writable
		end
	end

	// Bus state; control bits come up cleared
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rw_q <= bus_pin_ctrl_pkg::RW_BITS_RESET;
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			rw_q <= rw_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drive: modelled bus clock and the two active-low enables
	logic bclk_q;
	logic sclk_q;
	logic sclk_d;
	logic mem_oe_n_q;
	logic mem_oe_n_d;
	logic clk_oe_n_q;
	logic clk_oe_n_d;
	logic parked;

	// Pin drive; enables are active low, high means floating
	always_comb begin
		// Secondary clock copies the bus clock or sits low
		sclk_d = rw_q[bus_pin_ctrl_pkg::SEC_CLK_DRIVE_BIT] ? !bclk_q : 1'b0;
		mem_oe_n_d = float_n(standby, rw_q[bus_pin_ctrl_pkg::MEM_FLOAT_BIT]);
		if (bus_released) begin
			mem_oe_n_d = 1'b1; // Release overrides the float bit
		end
		// Modes 4-6 need software to set the clock float bit
		parked = standby || bus_released;
		clk_oe_n_d = float_n(parked, rw_q[bus_pin_ctrl_pkg::CLK_FLOAT_BIT]);
	end

	// Pin state; everything floats while reset holds
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bclk_q <= 1'b0;
			sclk_q <= 1'b0;
			mem_oe_n_q <= 1'b1;
			clk_oe_n_q <= 1'b1;
		end else begin
			bclk_q <= !bclk_q;
			sclk_q <= sclk_d;
			mem_oe_n_q <= mem_oe_n_d;
			clk_oe_n_q <= clk_oe_n_d;
		end
	end

	// Bus outputs, each straight from a flop
	assign wb_dat_o = rdata_q;
	assign wb_ack_o = ack_q;

	// Pin outputs, each straight from a flop
	assign little_endian = order_q; // Single flag for all spaces
	assign bus_clock_pin = bclk_q;
	assign secondary_clock_pin = sclk_q;
	assign memory_pins_oe_n = mem_oe_n_q;
	assign clock_pins_oe_n = clk_oe_n_q;

endmodule : bus_pin_control_bits

// *** src/bus_pin_ctrl_pkg.sv ***
// Purpose: Shared constants for the bus pin control register bank
// Assumes: Wishbone classic, 32-bit data, byte addresses
// Notes: Only the low five bits of the common control word live here
package bus_pin_ctrl_pkg;
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam int RESERVED_BIT = 4;
	localparam int BYTE_ORDER_BIT = 3;
	localparam int SEC_CLK_DRIVE_BIT = 2;
	localparam int MEM_FLOAT_BIT = 1;
	localparam int CLK_FLOAT_BIT = 0;
	localparam logic RESERVED_VALUE = 1'b1;
	localparam logic [2:0] RW_BITS_RESET = 3'h0;
	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;
endpackage : bus_pin_ctrl_pkg

// *** verif/bus_pin_chk_assertions.sv ***
// Purpose: Bus and pin checks
// Assumes: One-cycle ack
// Notes: Float bits are unseen, so pin checks use the inputs
`timescale 1ns/1ps
module bus_pin_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic standby,
	input wire logic bus_released,
	input wire logic little_endian,
	input wire logic secondary_clock_pin,
	input wire logic memory_pins_oe_n,
	input wire logic clock_pins_oe_n,
	input wire logic [31:0] wb_dat_o
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Normal running, reset edge excluded since pins start floated
	sequence run_s; !$past(rst) && !$past(standby) && !$past(bus_released); endsequence
	a_ack_due: assert property (wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack");
	a_bit_one: assert property (|wb_dat_o |-> wb_dat_o[4]) else $error("bit");
	a_flag_read: assert property (wb_dat_o[4] |-> wb_dat_o[3] == little_endian)
		else $error("flag");
	a_sec_clock: assert property (secondary_clock_pin |=> !secondary_clock_pin)
		else $error("sec");
	a_bus_free: assert property ($past(bus_released) |-> memory_pins_oe_n)
		else $error("mem");
	a_mem_on: assert property (run_s |-> !memory_pins_oe_n) else $error("mem");
	a_clk_on: assert property (run_s |-> !clock_pins_oe_n) else $error("clk");
endmodule : bus_pin_chk
bind bus_pin_control_bits bus_pin_chk u_chk (.*);

// *** verif/bus_pin_control_bits_bench.sv ***
// Purpose: Bus and pin tests
// Assumes: One-cycle ack
// Notes: Runs once per strap level
`timescale 1ns/1ps
module bus_pin_control_bits_bench;
	logic clk, rst, wb_cyc_i, wb_we_i, level, byte_order_strap_pin, standby, bus_released, p, b;
	logic wb_ack_o, little_endian, bus_clock_pin, secondary_clock_pin, memory_pins_oe_n;
	logic clock_pins_oe_n;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, x;
	logic [3:0] wb_sel_i;
	wire logic wb_stb_i = wb_cyc_i;
	int n_errors, cmp_count;
	bus_pin_control_bits u_dut (
		.clk(clk),
		.rst(rst),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.byte_order_strap_pin(byte_order_strap_pin),
		.standby(standby),
		.bus_released(bus_released),
		.little_endian(little_endian),
		.bus_clock_pin(bus_clock_pin),
		.secondary_clock_pin(secondary_clock_pin),
		.memory_pins_oe_n(memory_pins_oe_n),
		.clock_pins_oe_n(clock_pins_oe_n)
	);
	strap_board u_board (
		.level(level),
		.byte_order_strap_pin(byte_order_strap_pin)
	);
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task chk(string s, logic [31:0] e, g);
		cmp_count++;
		n_errors += int'(g !== e);
		if (g !== e) $display("wrong value %s exp %h got %h", s, e, g);
	endtask : chk
	// Request held until ack is sampled; reads compare against d
	task wb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		{wb_cyc_i, wb_we_i, wb_adr_i, wb_dat_i} <= {1'b1, w, a, d};
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 0;
		if (!w) chk("word", d, wb_dat_o);
	endtask : wb
	// Pins lag inputs a cycle; two samples show a running clock
	task pins(logic s, logic r, logic [2:0] e);
		{standby, bus_released} <= {s, r};
		repeat (2) @(posedge clk);
		{p, b} = {secondary_clock_pin, bus_clock_pin};
		@(posedge clk);
		chk("pins", e, {memory_pins_oe_n, clock_pins_oe_n, p ^ secondary_clock_pin});
		chk("bus clock", 32'h1, {31'h0, b ^ bus_clock_pin});
	endtask : pins
	task end_sim;
		if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim
	initial begin
		#3000 n_errors++;
		end_sim;
	end
	// Second pass resets mid-run with the strap flipped
	initial begin
		{wb_cyc_i, wb_we_i, standby, bus_released, wb_adr_i, wb_dat_i} <= '0;
		wb_sel_i <= 4'hF;
		for (int i = 0; i < 2; i++) begin
			{level, rst} <= {i[0], 1'b1};
			repeat (5) @(posedge clk);
			rst <= 0;
			repeat (6) @(posedge clk);
			x = {28'h1, i[0], 3'h0};
			chk("endian", {31'h0, i[0]}, {31'h0, little_endian});
			wb(0, 8'h00, x);
			pins(1, 0, 3'h6);
			wb(1, 8'h00, x ^ 32'h0000_000F); // Bit 4 kept one, bit 3 flipped
			wb(0, 8'h00, x | 32'h7);
			wb_sel_i <= 4'hE;
			wb(1, 8'h00, 32'h10); // Lane 0 off, so ignored
			wb_sel_i <= 4'hF;
			wb(1, 8'h04, 32'h10); // Unmapped, so ignored
			wb(0, 8'h00, x | 32'h7);
			pins(1, 0, 3'h1);
			pins(0, 1, 3'h5);
			wb(0, 8'h04, 32'h0);
			wb(1, 8'h00, 32'h10);
			pins(1, 1, 3'h6);
		end
		end_sim;
	end
endmodule : bus_pin_control_bits_bench

// *** verif/strap_board.sv ***
// Purpose: Strap resistor on the board
// Assumes: Level is static across each reset
// Notes: No bus traffic is modelled
`timescale 1ns/1ps
module strap_board (
	input wire logic level,
	output logic byte_order_strap_pin
);
	assign byte_order_strap_pin = level;
endmodule : strap_board
